// [core/gpport_pkg.sv]
package gpport_pkg;
	localparam int unsigned PIN_COUNT = 6;
	localparam int unsigned INPUT_ONLY_PIN = 3;
	localparam logic [11:0] DIR_OFF = 12'h000;
	localparam logic [11:0] LEVEL_OFF = 12'h004;
	localparam logic [11:0] LATCH_OFF = 12'h008;
	localparam logic [11:0] ANALOG_OFF = 12'h00c;
	localparam logic [11:0] THRESH_OFF = 12'h010;
	localparam logic [11:0] OPEN_DRAIN_OFF = 12'h014;
	localparam logic [11:0] SLEW_OFF = 12'h018;
	localparam logic [11:0] PERIPH_OFF = 12'h01c;
	localparam logic [5:0] DIR_RESET = 6'h3f;
	localparam logic [5:0] LATCH_RESET = 6'h00;
	localparam logic [5:0] ANALOG_RESET = 6'h3f;
	localparam logic [5:0] THRESH_RESET = 6'h00;
	localparam logic [5:0] OPEN_DRAIN_RESET = 6'h00;
	localparam logic [5:0] SLEW_RESET = 6'h3f;
	localparam logic [5:0] PERIPH_RESET = 6'h00;
	localparam int unsigned APB_WAIT_CYCLES = 0;
endpackage

// [core/gpport_top.sv]
// Design decisions made here: register access over APB and the register offsets.
module gpport_top #(
	parameter int unsigned PINS = gpport_pkg::PIN_COUNT
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	output logic [PINS-1:0] pin_slew_limit,
	output logic [PINS-1:0] pin_schmitt_sel,
	output logic [PINS-1:0] pin_input_buf_en,
	input wire logic [PINS-1:0] periph_out,
	output logic [PINS-1:0] pin_digital_in
);
	initial begin
		if (PINS != gpport_pkg::PIN_COUNT) begin
			$error("gpport_top serves six pins only");
		end
	end

	localparam logic [PINS-1:0] ONLY_IN = PINS'(1) << gpport_pkg::INPUT_ONLY_PIN;

	logic [PINS-1:0] pin_direction_q, pin_direction_d;
	logic [PINS-1:0] output_latch_q, output_latch_d;
	logic [PINS-1:0] analog_input_select_q, analog_input_select_d;
	logic [PINS-1:0] input_threshold_select_q, input_threshold_select_d;
	logic [PINS-1:0] open_drain_select_q, open_drain_select_d;
	logic [PINS-1:0] slew_limit_select_q, slew_limit_select_d;
	logic [PINS-1:0] periph_enable_q, periph_enable_d;
	logic [PINS-1:0] sync1_q, sync2_q;
	logic [PINS-1:0] pin_level;
	logic [PINS-1:0] out_value;
	logic [31:0] prdata_d;
	logic wr_en;
	logic rd_en;
	logic hit;

	// The first stage feeds only the second, so metastability never reaches logic.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// The pad applies the chosen threshold; here it only steers the buffer.
	assign pin_schmitt_sel = input_threshold_select_q;
	assign pin_input_buf_en = ~analog_input_select_q;
	assign pin_level = sync2_q & ~analog_input_select_q;
	assign pin_digital_in = pin_level;
	assign pin_slew_limit = slew_limit_select_q;

	// Analog select is absent here on purpose: it must not touch the drive.
	always_comb begin
		out_value = output_latch_q;
		for (int i = 0; i < PINS; i++) begin
			if (periph_enable_q[i]) begin
				out_value[i] = periph_out[i];
			end
		end
		pin_oe = '0;
		for (int i = 0; i < PINS; i++) begin
			if (ONLY_IN[i] || pin_direction_q[i]) begin
				pin_oe[i] = 1'b0;
			end else if (open_drain_select_q[i]) begin
				pin_oe[i] = ~out_value[i];
			end else begin
				pin_oe[i] = 1'b1;
			end
		end
		pin_out = out_value & ~open_drain_select_q;
	end

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign pready = 1'b1;

	always_comb begin
		hit = 1'b1;
		if (paddr == gpport_pkg::DIR_OFF) begin
		end else if (paddr == gpport_pkg::LEVEL_OFF) begin
		end else if (paddr == gpport_pkg::LATCH_OFF) begin
		end else if (paddr == gpport_pkg::ANALOG_OFF) begin
		end else if (paddr == gpport_pkg::THRESH_OFF) begin
		end else if (paddr == gpport_pkg::OPEN_DRAIN_OFF) begin
		end else if (paddr == gpport_pkg::SLEW_OFF) begin
		end else if (paddr == gpport_pkg::PERIPH_OFF) begin
		end else begin
			hit = 1'b0;
		end
	end
	assign pslverr = psel && penable && !hit;

	always_comb begin
		pin_direction_d = pin_direction_q;
		output_latch_d = output_latch_q;
		analog_input_select_d = analog_input_select_q;
		input_threshold_select_d = input_threshold_select_q;
		open_drain_select_d = open_drain_select_q;
		slew_limit_select_d = slew_limit_select_q;
		periph_enable_d = periph_enable_q;
		if (wr_en) begin
			if (paddr == gpport_pkg::DIR_OFF) begin
				pin_direction_d = pwdata[PINS-1:0] | ONLY_IN;
			end else if (paddr == gpport_pkg::LEVEL_OFF) begin
				// The whole word replaces the latch, like a byte-wide store after its read.
				output_latch_d = pwdata[PINS-1:0];
			end else if (paddr == gpport_pkg::LATCH_OFF) begin
				output_latch_d = pwdata[PINS-1:0];
			end else if (paddr == gpport_pkg::ANALOG_OFF) begin
				analog_input_select_d = pwdata[PINS-1:0];
			end else if (paddr == gpport_pkg::THRESH_OFF) begin
				input_threshold_select_d = pwdata[PINS-1:0];
			end else if (paddr == gpport_pkg::OPEN_DRAIN_OFF) begin
				open_drain_select_d = pwdata[PINS-1:0];
			end else if (paddr == gpport_pkg::SLEW_OFF) begin
				slew_limit_select_d = pwdata[PINS-1:0];
			end else if (paddr == gpport_pkg::PERIPH_OFF) begin
				periph_enable_d = pwdata[PINS-1:0];
			end
		end
	end

	always_comb begin
		prdata_d = prdata;
		if (rd_en) begin
			prdata_d = '0;
			if (paddr == gpport_pkg::DIR_OFF) begin
				prdata_d[PINS-1:0] = pin_direction_q | ONLY_IN;
			end else if (paddr == gpport_pkg::LEVEL_OFF) begin
				prdata_d[PINS-1:0] = pin_level;
			end else if (paddr == gpport_pkg::LATCH_OFF) begin
				prdata_d[PINS-1:0] = output_latch_q;
			end else if (paddr == gpport_pkg::ANALOG_OFF) begin
				prdata_d[PINS-1:0] = analog_input_select_q;
			end else if (paddr == gpport_pkg::THRESH_OFF) begin
				prdata_d[PINS-1:0] = input_threshold_select_q;
			end else if (paddr == gpport_pkg::OPEN_DRAIN_OFF) begin
				prdata_d[PINS-1:0] = open_drain_select_q;
			end else if (paddr == gpport_pkg::SLEW_OFF) begin
				prdata_d[PINS-1:0] = slew_limit_select_q;
			end else if (paddr == gpport_pkg::PERIPH_OFF) begin
				prdata_d[PINS-1:0] = periph_enable_q;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pin_direction_q <= gpport_pkg::DIR_RESET;
			output_latch_q <= gpport_pkg::LATCH_RESET;
			analog_input_select_q <= gpport_pkg::ANALOG_RESET;
			input_threshold_select_q <= gpport_pkg::THRESH_RESET;
			open_drain_select_q <= gpport_pkg::OPEN_DRAIN_RESET;
			slew_limit_select_q <= gpport_pkg::SLEW_RESET;
			periph_enable_q <= gpport_pkg::PERIPH_RESET;
			prdata <= '0;
		end else begin
			pin_direction_q <= pin_direction_d;
			output_latch_q <= output_latch_d;
			analog_input_select_q <= analog_input_select_d;
			input_threshold_select_q <= input_threshold_select_d;
			open_drain_select_q <= open_drain_select_d;
			slew_limit_select_q <= slew_limit_select_d;
			periph_enable_q <= periph_enable_d;
			prdata <= prdata_d;
		end
	end

	a_only_in_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!pin_oe[gpport_pkg::INPUT_ONLY_PIN])
		else $error("input-only pin driven");
	a_dir_off_drv: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_en && paddr == gpport_pkg::DIR_OFF && pwdata[0]) |=> !pin_oe[0])
		else $error("input direction still drives");
	a_out_drive_val: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!pin_direction_q[0] && !open_drain_select_q[0] && !periph_enable_q[0])
		|-> (pin_oe[0] && pin_out[0] == output_latch_q[0]))
		else $error("output pin not driving latch");
	a_level_write_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_en && paddr == gpport_pkg::LEVEL_OFF)
		|=> output_latch_q == $past(pwdata[PINS-1:0]))
		else $error("pin-level write missed latch");
	a_latch_write_same: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_en && paddr == gpport_pkg::LATCH_OFF)
		|=> output_latch_q == $past(pwdata[PINS-1:0]))
		else $error("latch write wrong");
	a_analog_reads_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd_en && paddr == gpport_pkg::LEVEL_OFF)
		|=> (prdata[PINS-1:0] & analog_input_select_q) == '0)
		else $error("analog pin read nonzero");
	a_latch_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd_en && paddr == gpport_pkg::LATCH_OFF)
		|=> prdata[PINS-1:0] == $past(output_latch_q))
		else $error("latch read wrong");
	a_open_drain_sink: assert property (@(posedge sys_clk) disable iff (!rst_n)
		open_drain_select_q[0] |-> (!pin_out[0] && !(pin_oe[0] && out_value[0])))
		else $error("open-drain sourced current");
	a_pin_sync_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
		##2 (pin_level == ($past(pin_in, 2) & ~analog_input_select_q)))
		else $error("pin sync latency wrong");

	// A push-pull output pin must drive whenever its direction bit is clear.
	a_dir_on_drv: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!pin_direction_q[1] && !open_drain_select_q[1]) |-> pin_oe[1])
		else $error("output direction not driving");

	a_dir_reads_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd_en && paddr == gpport_pkg::DIR_OFF) |=> prdata[gpport_pkg::INPUT_ONLY_PIN])
		else $error("input-only direction read zero");

	a_level_read_pins: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd_en && paddr == gpport_pkg::LEVEL_OFF) |=> prdata[PINS-1:0] == $past(pin_level))
		else $error("pin-level read not pins");

	a_upper_read_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_en |=> prdata[31:PINS] == '0)
		else $error("unused read bits set");

	a_analog_no_buf: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_en && paddr == gpport_pkg::ANALOG_OFF)
		|=> pin_input_buf_en == ~$past(pwdata[PINS-1:0]))
		else $error("analog select left buffer on");

	a_slew_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_en && paddr == gpport_pkg::SLEW_OFF)
		|=> pin_slew_limit == $past(pwdata[PINS-1:0]))
		else $error("slew limit not applied");

	a_thresh_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_en && paddr == gpport_pkg::THRESH_OFF)
		|=> pin_schmitt_sel == $past(pwdata[PINS-1:0]))
		else $error("threshold select not applied");

	// The peripheral value must win over the latch while it owns the pin.
	a_periph_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(periph_enable_q[0] && !open_drain_select_q[0]) |-> pin_out[0] == periph_out[0])
		else $error("peripheral not driving pin");

	a_analog_keeps_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(analog_input_select_q[1] && !pin_direction_q[1] && !periph_enable_q[1]
		&& !open_drain_select_q[1]) |-> (pin_oe[1] && pin_out[1] == output_latch_q[1]))
		else $error("analog select stopped drive");

	a_od_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(open_drain_select_q[2] && !pin_direction_q[2] && !periph_enable_q[2]
		&& output_latch_q[2]) |-> !pin_oe[2])
		else $error("open-drain high still driven");

	// Checked without disable so that the value left by reset itself is seen.
	a_reset_analog: assert property (@(posedge sys_clk)
		$rose(rst_n) |-> analog_input_select_q == gpport_pkg::ANALOG_RESET)
		else $error("reset left pins digital");

	a_reset_latch_src: assert property (@(posedge sys_clk)
		$rose(rst_n) |-> periph_enable_q == gpport_pkg::PERIPH_RESET)
		else $error("reset left peripheral drive");

	a_write_one_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!wr_en |=> ($stable(pin_direction_q) && $stable(output_latch_q)
		&& $stable(analog_input_select_q)))
		else $error("register changed without write");

	a_unmapped_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_en && !hit) |=> ($stable(output_latch_q) && $stable(pin_direction_q)))
		else $error("unmapped write changed state");
endmodule

// [sim/gpport_pins.sv]
module gpport_pins (
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] ext_level,
	output logic [5:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// An undriven pin follows the outside level, so a released open-drain line never reads as driven.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// [sim/general_purpose_pin_port_tb.sv]
module general_purpose_pin_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] x;} gpport_row_t;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [5:0] pin_in, pin_out, pin_oe, slew, schm, buf_en, dig_in;
	logic [5:0] periph_out = 6'h00;
	logic [5:0] ext_level = 6'h08;
	logic [31:0] r;
	logic e;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	gpport_row_t rows [7];
	always #20 sys_clk = ~sys_clk;
	gpport_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_slew_limit(slew), .pin_schmitt_sel(schm), .pin_input_buf_en(buf_en),
		.periph_out(periph_out), .pin_digital_in(dig_in));
	gpport_pins pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));
	task results();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// A cut-off keeps a stuck handshake from hanging the run.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			results();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Read data is taken at the edge that samples pready, before that edge's updates land.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask
	initial begin
		rows[0] = '{gpport_pkg::DIR_OFF, 32'h0, 32'h8};
		rows[1] = '{gpport_pkg::LATCH_OFF, 32'h2a, 32'h2a};
		rows[2] = '{gpport_pkg::ANALOG_OFF, 32'h0, 32'h0};
		rows[3] = '{gpport_pkg::THRESH_OFF, 32'h15, 32'h15};
		rows[4] = '{gpport_pkg::OPEN_DRAIN_OFF, 32'h0, 32'h0};
		rows[5] = '{gpport_pkg::SLEW_OFF, 32'h0, 32'h0};
		rows[6] = '{gpport_pkg::PERIPH_OFF, 32'h0, 32'h0};
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		chk({26'h0, pin_oe}, 32'h0);
		chk({31'h0, pready}, 32'h1);
		rd(gpport_pkg::ANALOG_OFF, 32'h3f);
		rd(gpport_pkg::SLEW_OFF, 32'h3f);
		// Thresholds are written while every peripheral enable is still clear.
		for (int i = 0; i < 7; i++) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].x);
		end
		repeat (3) @(posedge sys_clk);
		chk({26'h0, pin_oe}, 32'h37);
		chk({26'h0, pin_out & 6'h37}, 32'h22);
		chk({26'h0, slew, schm, buf_en}, 32'h0057f);
		rd(gpport_pkg::LEVEL_OFF, 32'h2a);
		$display("test table done");
		wr(gpport_pkg::DIR_OFF, 32'h3f);
		ext_level <= 6'h2d;
		repeat (3) @(posedge sys_clk);
		chk({26'h0, pin_oe, dig_in}, 32'h02d);
		rd(gpport_pkg::LEVEL_OFF, 32'h2d);
		rd(gpport_pkg::LATCH_OFF, 32'h2a);
		wr(gpport_pkg::ANALOG_OFF, 32'h05);
		rd(gpport_pkg::LEVEL_OFF, 32'h28);
		chk({26'h0, buf_en, dig_in}, 32'hea8);
		wr(gpport_pkg::LEVEL_OFF, 32'h11);
		rd(gpport_pkg::LATCH_OFF, 32'h11);
		$display("test input done");
		wr(gpport_pkg::DIR_OFF, 32'h0);
		wr(gpport_pkg::ANALOG_OFF, 32'h3f);
		chk({26'h0, pin_oe, pin_out & 6'h37}, 32'hdd1);
		wr(gpport_pkg::OPEN_DRAIN_OFF, 32'h3f);
		wr(gpport_pkg::LATCH_OFF, 32'h05);
		chk({26'h0, pin_oe, pin_out}, 32'hc80);
		wr(gpport_pkg::OPEN_DRAIN_OFF, 32'h0);
		wr(gpport_pkg::ANALOG_OFF, 32'h0);
		periph_out <= 6'h2c;
		wr(gpport_pkg::PERIPH_OFF, 32'h3f);
		repeat (3) @(posedge sys_clk);
		chk({26'h0, pin_out & 6'h37}, 32'h24);
		rd(gpport_pkg::LEVEL_OFF, 32'h2c);
		$display("test drive done");
		apb(1'b1, 12'h020, 32'h3f);
		chk({31'h0, e}, 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		chk({r[31:1], e}, 32'h1);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		chk({26'h0, pin_oe}, 32'h0);
		rd(gpport_pkg::DIR_OFF, 32'h3f);
		$display("test error and reset done");
		results();
	end
endmodule
